/* File: core/byte_port_pkg.sv */
// Purpose : Constants shared by the byte port with slave control block
// Assumes : AHB-Lite word registers, byte address is four times the index
// Notes   : Index values keep the printed register numbering
package byte_port_pkg;
   // -------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------
   localparam int BYTE_W    = 8;
   localparam int CTRL_W    = 3;
   localparam int IDX_W     = 10;
   localparam int IDX_LSB   = 2;

   // -------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // -------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_BYTE_DATA = 10'h008;
   localparam logic [IDX_W-1:0] IDX_CTRL_DATA = 10'h009;
   localparam logic [IDX_W-1:0] IDX_BYTE_DIR  = 10'h088;
   localparam logic [IDX_W-1:0] IDX_CTRL_STAT = 10'h089;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 10'h00C;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN    = 10'h08C;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR   = 10'h00D;

   // -------------------------------------------------------------
   // Field positions of the control direction and slave status word, the interrupt bit and the control pins
   // -------------------------------------------------------------
   localparam int POS_IN_FULL  = 7;
   localparam int POS_OUT_FULL = 6;
   localparam int POS_OVERRUN  = 5;
   localparam int POS_MODE     = 4;
   localparam int POS_IRQ      = 7;
   localparam int POS_RD_PIN   = 0;
   localparam int POS_WR_PIN   = 1;
   localparam int POS_CS_PIN   = 2;

   // -------------------------------------------------------------
   // Reset values and the all-zero word
   // -------------------------------------------------------------
   localparam logic [BYTE_W-1:0] RST_BYTE_DIR = 8'hFF;
   localparam logic [CTRL_W-1:0] RST_CTRL_DIR = 3'h7;
   localparam logic [31:0]       ZERO_WORD    = 32'h0000_0000;

   // AHB transfer type bit that marks an active transfer
   localparam int HTRANS_ACT = 1;
endpackage : byte_port_pkg

/* File: core/byte_port_slave.sv */
// Purpose : 8-bit byte port plus 3-pin control port with slave mode
// Assumes : One clock, strobes from the external master are asynchronous
// Notes   : Zero-wait AHB-Lite slave, one level interrupt output
//
// How it works
// - CPU port read returns pin levels, or the received byte in slave mode
// - CPU port write stores output latch
// - Read-modify-write latches sampled pin levels
// - Each control pin has direction bit
// - Slave mode: control pins become strobe inputs
// - Bit four selects slave or general mode
// - Low read strobe with select reads port
// - Low write strobe with select writes port
// - Chip select low selects, high ignores
// - Input full flags unread received byte
// - Output full flags unread CPU byte
// - Overrun sets on write while full
// - Bit three zero; status reset values
// - Direction resets ones, latches keep value
// - CPU input read clears input full
// - Master read clears output full
// - Overrun keeps first byte, drops second
// - Access completion sets gated interrupt flag
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module byte_port_slave
   import byte_port_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      ce,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // Byte port pins
   input  wire logic [byte_port_pkg::BYTE_W-1:0] bytePinIn,
   output logic      [byte_port_pkg::BYTE_W-1:0] bytePinOut,
   output logic      [byte_port_pkg::BYTE_W-1:0] bytePinOe,
   // Control port pins
   input  wire logic [byte_port_pkg::CTRL_W-1:0] ctrlPinIn,
   output logic      [byte_port_pkg::CTRL_W-1:0] ctrlPinOut,
   output logic      [byte_port_pkg::CTRL_W-1:0] ctrlPinOe,
   // Interrupt
   output logic                           irq
);
   import byte_port_pkg::*;

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   logic                 dpValid_reg;
   logic                 dpWrite_reg;
   logic [IDX_W-1:0]     dpIdx_reg;
   logic [BYTE_W-1:0]    byteSync1_reg;
   logic [BYTE_W-1:0]    byteSync2_reg;
   logic [CTRL_W-1:0]    ctrlSync1_reg;
   logic [CTRL_W-1:0]    ctrlSync2_reg;
   logic [BYTE_W-1:0]    byteLatch_reg;
   logic [CTRL_W-1:0]    ctrlLatch_reg;
   logic [BYTE_W-1:0]    byteDir_reg;
   logic [CTRL_W-1:0]    ctrlDir_reg;
   logic                 slaveMode_reg;
   logic                 inFull_reg;
   logic                 outFull_reg;
   logic                 overrun_reg;
   logic [BYTE_W-1:0]    inLatch_reg;
   logic [BYTE_W-1:0]    wrData_reg;
   logic                 extRdPrev_reg;
   logic                 extWrPrev_reg;
   logic                 irqFlag_reg;
   logic                 irqEn_reg;
   logic                 extRdOe_reg;
   logic                 cpuWr;
   logic                 cpuRd;
   logic                 extRd;
   logic                 extWr;
   logic                 rdDone;
   logic                 wrDone;
   logic                 inTaken;
   logic                 accept;
   logic [BYTE_W-1:0]    ctrlStatWord;

   // Register hit on a data-phase index
   function automatic logic hit(input logic [IDX_W-1:0] idx,
                                input logic [IDX_W-1:0] target);
      return idx == target;
   endfunction : hit

   // -------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------
   // Capture the address phase; only active transfers open a data phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dpValid_reg <= 1'b0;
         dpWrite_reg <= 1'b0;
         dpIdx_reg   <= '0;
      end else if (ce) begin
         if (hready) begin
            dpValid_reg <= hsel & htrans[HTRANS_ACT];
            dpWrite_reg <= hwrite;
            dpIdx_reg   <= haddr[IDX_LSB +: IDX_W];
         end
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign cpuWr     = ce & dpValid_reg & dpWrite_reg;
   assign cpuRd     = ce & dpValid_reg & ~dpWrite_reg;

   // Bit three and bits above the byte read as zero
   assign ctrlStatWord = {inFull_reg, outFull_reg, overrun_reg, slaveMode_reg,
                          1'b0, ctrlDir_reg};

   // Read mux over the data-phase index; unmapped reads return zero
   always_comb begin
      hrdata = ZERO_WORD;
      if (!dpValid_reg || dpWrite_reg) begin
         hrdata = ZERO_WORD;
      end else if (hit(dpIdx_reg, IDX_BYTE_DATA)) begin
         // Slave mode reads the received byte, otherwise the pins
         hrdata[BYTE_W-1:0] = slaveMode_reg ? inLatch_reg : byteSync2_reg;
      end else if (hit(dpIdx_reg, IDX_CTRL_DATA)) begin
         hrdata[CTRL_W-1:0] = ctrlSync2_reg;
      end else if (hit(dpIdx_reg, IDX_BYTE_DIR)) begin
         hrdata[BYTE_W-1:0] = byteDir_reg;
      end else if (hit(dpIdx_reg, IDX_CTRL_STAT)) begin
         hrdata[BYTE_W-1:0] = ctrlStatWord;
      end else if (hit(dpIdx_reg, IDX_IRQ_STAT)) begin
         hrdata[POS_IRQ] = irqFlag_reg;
      end else if (hit(dpIdx_reg, IDX_IRQ_EN)) begin
         hrdata[POS_IRQ] = irqEn_reg;
      end
   end

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   // Two stages; only the second stage feeds any logic
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         byteSync1_reg <= '0;
         byteSync2_reg <= '0;
         ctrlSync1_reg <= RST_CTRL_DIR;
         ctrlSync2_reg <= RST_CTRL_DIR;
      end else if (ce) begin
         byteSync1_reg <= bytePinIn;
         byteSync2_reg <= byteSync1_reg;
         ctrlSync1_reg <= ctrlPinIn;
         ctrlSync2_reg <= ctrlSync1_reg;
      end
   end

   // -------------------------------------------------------------
   // Strobe decode
   // -------------------------------------------------------------
   // Strobes only count while selected and in slave mode
   assign extRd  = slaveMode_reg & ~ctrlSync2_reg[POS_CS_PIN]
                   & ~ctrlSync2_reg[POS_RD_PIN];
   assign extWr  = slaveMode_reg & ~ctrlSync2_reg[POS_CS_PIN]
                   & ~ctrlSync2_reg[POS_WR_PIN];
   // Completion is the trailing edge, so each access acts once
   assign rdDone = ce & extRdPrev_reg & ~extRd & slaveMode_reg;
   assign wrDone = ce & extWrPrev_reg & ~extWr & slaveMode_reg;
   // A CPU read of the input byte in the same cycle frees the latch
   assign inTaken = cpuRd & hit(dpIdx_reg, IDX_BYTE_DATA) & slaveMode_reg;
   assign accept  = wrDone & (~inFull_reg | inTaken);

   // Strobe history and drive enable for master reads
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         extRdPrev_reg <= 1'b0;
         extWrPrev_reg <= 1'b0;
         extRdOe_reg   <= 1'b0;
      end else if (ce) begin
         extRdPrev_reg <= extRd;
         extWrPrev_reg <= extWr;
         extRdOe_reg   <= extRd;
      end
   end

   // Track the byte on the pins while the write strobe is low
   always_ff @(posedge clk) begin
      if (ce && extWr) begin
         wrData_reg <= byteSync2_reg;
      end
   end

   // -------------------------------------------------------------
   // Output latches (no reset: they survive every reset)
   // -------------------------------------------------------------
   // The CPU brings read-modify-write results, built from pin levels
   always_ff @(posedge clk) begin
      if (cpuWr && hit(dpIdx_reg, IDX_BYTE_DATA)) begin
         byteLatch_reg <= hwdata[BYTE_W-1:0];
      end
      if (cpuWr && hit(dpIdx_reg, IDX_CTRL_DATA)) begin
         ctrlLatch_reg <= hwdata[CTRL_W-1:0];
      end
   end

   // -------------------------------------------------------------
   // Direction and mode
   // -------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         byteDir_reg   <= RST_BYTE_DIR;
         ctrlDir_reg   <= RST_CTRL_DIR;
         slaveMode_reg <= 1'b0;
      end else if (cpuWr) begin
         if (hit(dpIdx_reg, IDX_BYTE_DIR)) begin
            byteDir_reg <= hwdata[BYTE_W-1:0];
         end
         if (hit(dpIdx_reg, IDX_CTRL_STAT)) begin
            ctrlDir_reg   <= hwdata[CTRL_W-1:0];
            slaveMode_reg <= hwdata[POS_MODE];
         end
      end
   end

   // -------------------------------------------------------------
   // Received byte
   // -------------------------------------------------------------
   // On overrun the first byte stays, the second is dropped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         inLatch_reg <= '0;
      end else if (accept) begin
         inLatch_reg <= wrData_reg;
      end
   end

   // -------------------------------------------------------------
   // Slave status flags
   // -------------------------------------------------------------
   // Input full: set wins over a same-cycle CPU read
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         inFull_reg <= 1'b0;
      end else if (ce) begin
         if (!slaveMode_reg) begin
            inFull_reg <= 1'b0;
         end else if (accept) begin
            inFull_reg <= 1'b1;
         end else if (inTaken) begin
            inFull_reg <= 1'b0;
         end
      end
   end

   // Output full: a CPU write sets it, a master read clears it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         outFull_reg <= 1'b0;
      end else if (ce) begin
         if (!slaveMode_reg) begin
            outFull_reg <= 1'b0;
         end else if (cpuWr && hit(dpIdx_reg, IDX_BYTE_DATA)) begin
            outFull_reg <= 1'b1;
         end else if (rdDone) begin
            outFull_reg <= 1'b0;
         end
      end
   end

   // Overrun: sticky, survives leaving slave mode, cleared by software
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         overrun_reg <= 1'b0;
      end else if (ce) begin
         if (wrDone && inFull_reg && !inTaken) begin
            overrun_reg <= 1'b1;
         end else if (cpuWr && hit(dpIdx_reg, IDX_CTRL_STAT)) begin
            overrun_reg <= hwdata[POS_OVERRUN];
         end
      end
   end

   // -------------------------------------------------------------
   // Interrupt
   // -------------------------------------------------------------
   // Completion flag is sticky; clear register writes ones to clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqFlag_reg <= 1'b0;
         irqEn_reg   <= 1'b0;
      end else if (ce) begin
         if (rdDone || wrDone) begin
            irqFlag_reg <= 1'b1;
         end else if (cpuWr && hit(dpIdx_reg, IDX_IRQ_CLR) && hwdata[POS_IRQ]) begin
            irqFlag_reg <= 1'b0;
         end
         if (cpuWr && hit(dpIdx_reg, IDX_IRQ_EN)) begin
            irqEn_reg <= hwdata[POS_IRQ];
         end
      end
   end

   assign irq = irqFlag_reg & irqEn_reg;

   // -------------------------------------------------------------
   // Pin drivers
   // -------------------------------------------------------------
   // Slave mode ignores byte direction; the master steers the bus
   assign bytePinOut = byteLatch_reg;
   assign bytePinOe  = slaveMode_reg ? {BYTE_W{extRdOe_reg}} : ~byteDir_reg;
   assign ctrlPinOut = ctrlLatch_reg;
   // Control pins never drive in slave mode, even if misprogrammed
   assign ctrlPinOe  = slaveMode_reg ? '0 : ~ctrlDir_reg;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_mode_full_clear;
      @(posedge clk) disable iff (reset)
      (ce && !slaveMode_reg) |=> (!inFull_reg && !outFull_reg);
   endproperty
   a_mode_full_clear: assert property (p_mode_full_clear)
      else $error("full flags not held clear outside slave mode");

   property p_in_full_set;
      @(posedge clk) disable iff (reset)
      (accept && slaveMode_reg) |=> inFull_reg && (inLatch_reg == $past(wrData_reg));
   endproperty
   a_in_full_set: assert property (p_in_full_set)
      else $error("input full or byte not captured after write");

   property p_in_read_clears;
      @(posedge clk) disable iff (reset)
      (inTaken && !wrDone) |=> !inFull_reg;
   endproperty
   a_in_read_clears: assert property (p_in_read_clears)
      else $error("input full not cleared by cpu read");

   property p_overrun_keeps;
      @(posedge clk) disable iff (reset)
      (wrDone && inFull_reg && !inTaken) |=> overrun_reg && $stable(inLatch_reg);
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps)
      else $error("overrun not flagged or first byte lost");

   property p_overrun_sticky;
      @(posedge clk) disable iff (reset)
      (overrun_reg && !cpuWr) |=> overrun_reg;
   endproperty
   a_overrun_sticky: assert property (p_overrun_sticky)
      else $error("overrun cleared without software");

   property p_out_full;
      @(posedge clk) disable iff (reset)
      (slaveMode_reg && cpuWr && hit(dpIdx_reg, IDX_BYTE_DATA)) |=> outFull_reg;
   endproperty
   a_out_full: assert property (p_out_full)
      else $error("output full not set by cpu write");

   property p_ext_read_done;
      @(posedge clk) disable iff (reset)
      (rdDone && !cpuWr) |=> (!outFull_reg && irqFlag_reg);
   endproperty
   a_ext_read_done: assert property (p_ext_read_done)
      else $error("master read completion mishandled");

   property p_once_per_access;
      @(posedge clk) disable iff (reset)
      wrDone |=> !wrDone;
   endproperty
   a_once_per_access: assert property (p_once_per_access)
      else $error("write completion seen twice");

   property p_irq_level;
      @(posedge clk) disable iff (reset)
      (rdDone || wrDone) |=> (irqFlag_reg && (irq == irqEn_reg));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("completion did not raise the gated interrupt");

   property p_ctrl_no_drive;
      @(posedge clk) disable iff (reset)
      slaveMode_reg |-> (ctrlPinOe == '0);
   endproperty
   a_ctrl_no_drive: assert property (p_ctrl_no_drive)
      else $error("control pins driven in slave mode");

   property p_bit3_zero;
      @(posedge clk) disable iff (reset)
      ctrlStatWord[3] == 1'b0;
   endproperty
   a_bit3_zero: assert property (p_bit3_zero)
      else $error("unimplemented bit reads one");

   c_ext_write: cover property (@(posedge clk) disable iff (reset) accept);
   c_ext_read:  cover property (@(posedge clk) disable iff (reset) rdDone);
   c_overrun:   cover property (@(posedge clk) disable iff (reset) $rose(overrun_reg));
   c_irq:       cover property (@(posedge clk) disable iff (reset) $rose(irq));
endmodule : byte_port_slave

/* File: dv/ext_master.sv */
// Purpose : External 8-bit processor model facing the slave port pins
// Assumes : Strobes held at least 3 clocks low and 3 clocks high
// Notes   : Released data lines show the inverse of the last value
`timescale 1ns/1ps
module ext_master (
   // Clock
   input  wire logic                             clk,
   // Device pin outputs
   input  wire logic [byte_port_pkg::BYTE_W-1:0] bytePinOut,
   input  wire logic [byte_port_pkg::BYTE_W-1:0] bytePinOe,
   input  wire logic [byte_port_pkg::CTRL_W-1:0] ctrlPinOut,
   input  wire logic [byte_port_pkg::CTRL_W-1:0] ctrlPinOe,
   // Resolved pin levels
   output logic      [byte_port_pkg::BYTE_W-1:0] bytePinIn,
   output logic      [byte_port_pkg::CTRL_W-1:0] ctrlPinIn
);
   import byte_port_pkg::*;
   logic [BYTE_W-1:0] dq;
   logic              drv;
   logic [CTRL_W-1:0] ctl;
   // Each bit follows whoever drives it; undriven data shows a changed value
   assign bytePinIn = (bytePinOe & bytePinOut) | (~bytePinOe & (drv ? dq : ~dq));
   assign ctrlPinIn = (ctrlPinOe & ctrlPinOut) | (~ctrlPinOe & ctl);
   initial begin
      dq  = 8'h00;
      drv = 1'b0;
      ctl = 3'h7;
   end
   // Plain pin drive for general purpose mode
   task automatic drive(input logic [7:0] d, input logic on);
      @(posedge clk);
      dq  <= d;
      drv <= on;
   endtask : drive
   // Write strobe; data stays put three clocks past release
   task automatic ext_write(input logic [7:0] d, input int n, input logic csN);
      @(posedge clk);
      dq  <= d;
      drv <= 1'b1;
      ctl <= {csN, 2'b01};
      repeat (n) @(posedge clk);
      ctl <= 3'h7;
      repeat (3) @(posedge clk);
      drv <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : ext_write
   // Read strobe; n of 4 or more lets the device turn its drivers on
   task automatic ext_read(output logic [7:0] d, input int n, input logic csN);
      @(posedge clk);
      ctl <= {csN, 2'b10};
      repeat (n) @(posedge clk);
      d = bytePinIn;
      ctl <= 3'h7;
      repeat (4) @(posedge clk);
   endtask : ext_read
endmodule : ext_master

/* File: dv/byte_port_slave_tb.sv */
// Purpose : Self-checking bench for the byte port with slave control
// Assumes : Zero-wait slave, hready taken from hreadyout
// Notes   : Register access only through AHB-Lite single word transfers
`timescale 1ns/1ps
module byte_port_slave_tb;
   import byte_port_pkg::*;
   logic              clk, reset, ce, hsel, hwrite, hready, hresp, irq;
   logic [31:0]       haddr, hwdata, hrdata, rv;
   logic [1:0]        htrans;
   logic [BYTE_W-1:0] bytePinIn, bytePinOut, bytePinOe, ev;
   logic [CTRL_W-1:0] ctrlPinIn, ctrlPinOut, ctrlPinOe;
   int                fail_count, total_checks, cycles;
   byte_port_slave dut (.clk(clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .bytePinIn(bytePinIn),
      .bytePinOut(bytePinOut), .bytePinOe(bytePinOe), .ctrlPinIn(ctrlPinIn),
      .ctrlPinOut(ctrlPinOut), .ctrlPinOe(ctrlPinOe), .irq(irq));
   ext_master u_ext (.clk(clk), .bytePinOut(bytePinOut), .bytePinOe(bytePinOe),
      .ctrlPinOut(ctrlPinOut), .ctrlPinOe(ctrlPinOe), .bytePinIn(bytePinIn),
      .ctrlPinIn(ctrlPinIn));
   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One single transfer; read data taken at the data phase edge
   task automatic xfer(input logic [IDX_W-1:0] i, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {20'h0, i, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rv = hrdata;
      hsel <= 1'b0;
   endtask : xfer
   // One extra edge so the written register is settled before any compare
   task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
      xfer(i, 1'b1, {24'h0, d});
      @(posedge clk);
   endtask : wr
   task automatic rc(input string nm, input logic [IDX_W-1:0] i, input logic [7:0] e);
      xfer(i, 1'b0, ZERO_WORD);
      chk(nm, rv, {24'h0, e});
   endtask : rc
   task automatic close_out();
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // Clock and hang guard
   // ------------------------------------------------------------
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      clk = 1'b0; reset = 1'b1; ce = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00;
      haddr = ZERO_WORD; hwdata = ZERO_WORD; cycles = 0; fail_count = 0; total_checks = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rc("byte_dir", IDX_BYTE_DIR, 8'hFF);
      rc("ctrl_stat", IDX_CTRL_STAT, 8'h07);
      chk("byte_oe", bytePinOe, 8'h00);
      rc("unmapped", 10'h001, 8'h00);
      chk("hresp", hresp, 1'b0);
      wr(10'h001, 8'h5A);
      $display("Test reset done");
      // General purpose: upper pins outputs, lower pins driven from outside
      wr(IDX_BYTE_DIR, 8'h0F);
      wr(IDX_BYTE_DATA, 8'hA5);
      u_ext.drive(8'h3C, 1'b1);
      repeat (4) @(posedge clk);
      chk("byte_oe", bytePinOe, 8'hF0);
      rc("byte_pins", IDX_BYTE_DATA, 8'hAC);
      xfer(IDX_BYTE_DATA, 1'b0, ZERO_WORD);
      wr(IDX_BYTE_DATA, rv[7:0] | 8'h01);
      chk("byte_latch", bytePinOut, 8'hAD);
      u_ext.drive(8'h3C, 1'b0);
      wr(IDX_CTRL_STAT, 8'h0A);
      rc("ctrl_dir", IDX_CTRL_STAT, 8'h02);
      chk("ctrl_oe", ctrlPinOe, 3'h5);
      wr(IDX_CTRL_DATA, 8'h05);
      chk("ctrl_latch", ctrlPinOut, 3'h5);
      repeat (4) @(posedge clk);
      rc("ctrl_pins", IDX_CTRL_DATA, 8'h07);
      $display("Test gpio done");
      // Slave mode: two writes in a row give an overrun
      wr(IDX_CTRL_STAT, 8'h17);
      chk("ctrl_oe_slave", ctrlPinOe, 3'h0);
      wr(IDX_IRQ_EN, 8'h80);
      u_ext.ext_write(8'h5A, 3, 1'b0);
      repeat (3) @(posedge clk);
      rc("stat_full", IDX_CTRL_STAT, 8'h97);
      chk("irq_set", irq, 1'b1);
      u_ext.ext_write(8'h11, 8, 1'b0);
      repeat (3) @(posedge clk);
      rc("stat_ovr", IDX_CTRL_STAT, 8'hB7);
      rc("in_byte", IDX_BYTE_DATA, 8'h5A);
      rc("stat_read", IDX_CTRL_STAT, 8'h37);
      wr(IDX_CTRL_STAT, 8'h17);
      rc("stat_ovr_clr", IDX_CTRL_STAT, 8'h17);
      wr(IDX_IRQ_CLR, 8'h80);
      rc("irq_stat_clr", IDX_IRQ_STAT, 8'h00);
      chk("irq_clr", irq, 1'b0);
      $display("Test slave write done");
      // Slave read of a CPU byte
      wr(IDX_BYTE_DATA, 8'hC3);
      rc("stat_out", IDX_CTRL_STAT, 8'h57);
      u_ext.ext_read(ev, 5, 1'b0);
      chk("ext_read", ev, 8'hC3);
      repeat (3) @(posedge clk);
      rc("stat_out_clr", IDX_CTRL_STAT, 8'h17);
      rc("irq_stat_rd", IDX_IRQ_STAT, 8'h80);
      wr(IDX_IRQ_CLR, 8'h80);
      $display("Test slave read done");
      // Deselected strobes, then a masked flag
      u_ext.ext_write(8'h66, 3, 1'b1);
      u_ext.ext_read(ev, 5, 1'b1);
      repeat (3) @(posedge clk);
      rc("stat_desel", IDX_CTRL_STAT, 8'h17);
      rc("irq_desel", IDX_IRQ_STAT, 8'h00);
      wr(IDX_IRQ_EN, 8'h00);
      u_ext.ext_write(8'h22, 3, 1'b0);
      repeat (3) @(posedge clk);
      chk("irq_masked", irq, 1'b0);
      rc("irq_stat_mask", IDX_IRQ_STAT, 8'h80);
      rc("in_byte2", IDX_BYTE_DATA, 8'h22);
      wr(IDX_IRQ_CLR, 8'h80);
      $display("Test select done");
      // Leaving slave mode clears the full flags; latch survives reset
      wr(IDX_BYTE_DATA, 8'h99);
      wr(IDX_CTRL_STAT, 8'h07);
      rc("stat_gpio", IDX_CTRL_STAT, 8'h07);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      chk("latch_kept", bytePinOut, 8'h99);
      rc("dir_rst", IDX_BYTE_DIR, 8'hFF);
      // Enable low freezes everything, so this write must be lost
      ce <= 1'b0;
      wr(IDX_BYTE_DIR, 8'h00);
      ce <= 1'b1;
      rc("dir_frozen", IDX_BYTE_DIR, 8'hFF);
      rc("stat_rst", IDX_CTRL_STAT, 8'h07);
      $display("Test mode and reset done");
      close_out();
   end
endmodule : byte_port_slave_tb
